/* logic/dmmch_map.svh */
`ifndef DMMCH_MAP_SVH
`define DMMCH_MAP_SVH
// register word indices (byte address = index * 4)
`define DMMCH_IDX_MODE 2'h0
`define DMMCH_IDX_CMD 2'h1
`define DMMCH_IDX_STATUS 2'h2
`define DMMCH_IDX_STATE 2'h3
// command register fields
`define DMMCH_OP_LSB 0
`define DMMCH_OP_MSB 3
`define DMMCH_BLK_LSB 4
`define DMMCH_BLK_MSB 8
// outbound command words and bits
`define DMMCH_CW_DISABLE 16'h0000
`define DMMCH_CW_SHUTDOWN 16'h0006
`define DMMCH_CW_SWITCHON 16'h0007
`define DMMCH_CW_ENABLE 16'h000f
`define DMMCH_CW_START 16'h020f
`define DMMCH_CW_RESUME 16'h004f
`define DMMCH_CW_CLRLIM 16'h001f
`define DMMCH_CW_SEQ 16'h0010
`define DMMCH_CW_HALT 16'h0100
`define DMMCH_CW_GO_BIT 9
`define DMMCH_CW_ENABLE_NIB 4'hf
// inbound state words
`define DMMCH_ST_DISABLED 16'h0050
`define DMMCH_ST_READY 16'h0031
`define DMMCH_ST_SWON 16'h0033
`define DMMCH_ST_SWON_LO 8'h33
`define DMMCH_ST_OPEN_LO 8'h37
`define DMMCH_ST_POS_LO 12'h337
`define DMMCH_ST_TARGET_BIT 10
// mode selection values
`define DMMCH_MODE_TABLE 16'hffff
`define DMMCH_MODE_LIMIT 16'hfffe
`define DMMCH_MODE_RESET 16'h0000
// bus answers
`define DMMCH_RESP_OKAY 2'h0
`define DMMCH_RESP_SLVERR 2'h2
`endif

/* logic/dmmch_pkg.sv */
package dmmch_pkg;
	typedef logic [15:0] dmmch_word_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DISV = 3'h1,
		ST_SHUT = 3'h3,
		ST_SWON = 3'h2,
		ST_ENOP = 3'h6,
		ST_READY = 3'h7
	} dmmch_state_e;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_POWERUP = 4'h1,
		OP_START = 4'h2,
		OP_START_SEQ = 4'h3,
		OP_RESUME = 4'h4,
		OP_RESUME_SEQ = 4'h5,
		OP_STOP = 4'h6,
		OP_CLEARLIM = 4'h7,
		OP_HALT = 4'h8,
		OP_RELEASE = 4'h9,
		OP_DISABLE = 4'ha
	} dmmch_op_e;
endpackage

/* logic/dmmch_host.sv */
// Chosen here: the address map and the AXI4-Lite register port.
`include "dmmch_map.svh"

// Functional notes
// - send 0x0000, 0x0006, 0x0007, 0x000F in order, each after its status reply.
// - table travel mode needs mode word 0xFFFF before the command sequence.
// - 0x020F starts block 1 as single motion.
// - block-select bits 15..11 pick block; 0x0A0F block 2, 0x120F block 3.
// - 0x021F starts an automatic sequence at block 1.
// - 0x004F resumes the interrupted block as single motion.
// - 0x005F resumes the interrupted block as automatic sequence.
// - bit 9 held high through positioning; clearing it interrupts motion.
// - mode word may change safely while 0x0007 is active.
// - check status 0xnn33 before changing mode; never while enabled. Here mode also goes out unchecked while 0x0000 is sent.
// - motion state changes only while command low nibble is all ones.
// - mode value 0xFFFE (minus two) selects limit-switch clearing.
module dmmch_host #(
	parameter int ADDR_W = 8
) (
	input logic clk,
	input logic reset,
	input logic [ADDR_W-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [ADDR_W-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	output dmmch_pkg::dmmch_word_t outboundProcessWordOne,
	output dmmch_pkg::dmmch_word_t outboundModeSelectWord,
	input dmmch_pkg::dmmch_word_t inboundProcessWordOne,
	input dmmch_pkg::dmmch_word_t inboundModeDisplayWord
);
	import dmmch_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, wdata_reg;
	logic [3:0] wstrb_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] syncA_reg, syncB_reg, syncC_reg, inStable_reg;
	dmmch_word_t cmdOut_reg, modeOut_reg, mode_reg;
	dmmch_state_e state_reg;
	logic refused_reg;
	logic wrEn, cmdPulse, cmdOk, awMapped, arMapped;
	dmmch_op_e opIn;
	logic [4:0] blkIn;
	dmmch_word_t statWord, dispWord, startWord, seqBit;
	logic posActive, targetReached, busy, modePending;

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign outboundProcessWordOne = cmdOut_reg;
	assign outboundModeSelectWord = modeOut_reg;

	// address and data are taken independently; the write acts once both are held
	always_ff @(posedge clk) begin
		if (reset) begin
			awready_reg <= 1'b1;
			awaddr_reg <= '0;
		end else if (s_axi_awvalid && awready_reg) begin
			awready_reg <= 1'b0;
			awaddr_reg <= s_axi_awaddr;
		end else if (bvalid_reg && s_axi_bready) begin
			awready_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wready_reg <= 1'b1;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid && wready_reg) begin
			wready_reg <= 1'b0;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end else if (bvalid_reg && s_axi_bready) begin
			wready_reg <= 1'b1;
		end
	end

	assign wrEn = !awready_reg && !wready_reg && !bvalid_reg;
	assign awMapped = (awaddr_reg[ADDR_W-1:4] == '0);
	assign arMapped = (s_axi_araddr[ADDR_W-1:4] == '0);

	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `DMMCH_RESP_OKAY;
		end else if (wrEn) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= awMapped ? `DMMCH_RESP_OKAY : `DMMCH_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mode_reg <= `DMMCH_MODE_RESET;
		end else if (wrEn && awMapped && awaddr_reg[3:2] == `DMMCH_IDX_MODE) begin
			if (wstrb_reg[0]) begin
				mode_reg[7:0] <= wdata_reg[7:0];
			end
			if (wstrb_reg[1]) begin
				mode_reg[15:8] <= wdata_reg[15:8];
			end
		end
	end

	assign cmdPulse = wrEn && awMapped && awaddr_reg[3:2] == `DMMCH_IDX_CMD && wstrb_reg[0];
	assign opIn = dmmch_op_e'(wdata_reg[`DMMCH_OP_MSB:`DMMCH_OP_LSB]);
	assign blkIn = wdata_reg[`DMMCH_BLK_MSB:`DMMCH_BLK_LSB];

	// inbound words cross from the fieldbus side; a bit changes once stages B and C agree
	always_ff @(posedge clk) begin
		if (reset) begin
			syncA_reg <= 32'h0;
			syncB_reg <= 32'h0;
			syncC_reg <= 32'h0;
			inStable_reg <= 32'h0;
		end else begin
			syncA_reg <= {inboundModeDisplayWord, inboundProcessWordOne};
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
			inStable_reg <= (~(syncB_reg ^ syncC_reg) & syncC_reg) |
				((syncB_reg ^ syncC_reg) & inStable_reg);
		end
	end

	assign statWord = inStable_reg[15:0];
	assign dispWord = inStable_reg[31:16];
	assign posActive = (statWord[11:0] == `DMMCH_ST_POS_LO);
	assign targetReached = statWord[`DMMCH_ST_TARGET_BIT];
	assign busy = (state_reg != ST_IDLE) && (state_reg != ST_READY);
	assign modePending = (mode_reg != modeOut_reg);
	assign seqBit = (opIn == OP_START_SEQ || opIn == OP_RESUME_SEQ) ? `DMMCH_CW_SEQ : 16'h0000;
	assign startWord = `DMMCH_CW_START | {blkIn, 11'h000} | seqBit;

	always_comb begin
		cmdOk = 1'b0;
		unique case (opIn)
			OP_NONE, OP_DISABLE: cmdOk = 1'b1;
			OP_POWERUP: cmdOk = (state_reg == ST_IDLE);
			// a start needs bit 9 low first so the drive sees a rising edge
			OP_START, OP_START_SEQ: cmdOk = (state_reg == ST_READY) &&
				(modeOut_reg == `DMMCH_MODE_TABLE) && !cmdOut_reg[`DMMCH_CW_GO_BIT];
			// a resume word drops bit 9, so it must not cut a running positioning short
			OP_RESUME, OP_RESUME_SEQ: cmdOk = (state_reg == ST_READY) &&
				(modeOut_reg == `DMMCH_MODE_TABLE) &&
				!cmdOut_reg[`DMMCH_CW_GO_BIT];
			OP_CLEARLIM: cmdOk = (state_reg == ST_READY) &&
				(modeOut_reg == `DMMCH_MODE_LIMIT);
			OP_STOP, OP_HALT, OP_RELEASE: cmdOk = (state_reg == ST_READY);
			default: cmdOk = 1'b0;
		endcase
	end

	// power-up stepping and the command word sent to the drive
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			cmdOut_reg <= `DMMCH_CW_DISABLE;
		end else if (cmdPulse && cmdOk && opIn == OP_DISABLE) begin
			state_reg <= ST_IDLE;
			cmdOut_reg <= `DMMCH_CW_DISABLE;
		end else if (cmdPulse && cmdOk && opIn == OP_POWERUP) begin
			state_reg <= ST_DISV;
			cmdOut_reg <= `DMMCH_CW_DISABLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
				end
				ST_DISV: if (statWord == `DMMCH_ST_DISABLED) begin
					state_reg <= ST_SHUT;
					cmdOut_reg <= `DMMCH_CW_SHUTDOWN;
				end
				ST_SHUT: if (statWord == `DMMCH_ST_READY) begin
					state_reg <= ST_SWON;
					cmdOut_reg <= `DMMCH_CW_SWITCHON;
				end
				// enabling waits until any pending mode change has gone out
				ST_SWON: if (statWord == `DMMCH_ST_SWON && !modePending) begin
					state_reg <= ST_ENOP;
					cmdOut_reg <= `DMMCH_CW_ENABLE;
				end
				ST_ENOP: if (statWord[7:0] == `DMMCH_ST_OPEN_LO) begin
					state_reg <= ST_READY;
				end
				ST_READY: if (cmdPulse && cmdOk) begin
					unique case (opIn)
						OP_START, OP_START_SEQ: cmdOut_reg <= startWord;
						OP_RESUME, OP_RESUME_SEQ: cmdOut_reg <= `DMMCH_CW_RESUME | seqBit;
						OP_STOP: cmdOut_reg <= `DMMCH_CW_ENABLE;
						OP_CLEARLIM: cmdOut_reg <= `DMMCH_CW_CLRLIM;
						OP_HALT: cmdOut_reg <= cmdOut_reg | `DMMCH_CW_HALT;
						OP_RELEASE: cmdOut_reg <= cmdOut_reg & ~`DMMCH_CW_HALT;
						default: begin
						end
					endcase
				end
			endcase
		end
	end

	// mode goes out only with voltage disabled or switched on confirmed
	always_ff @(posedge clk) begin
		if (reset) begin
			modeOut_reg <= `DMMCH_MODE_RESET;
		end else if (cmdOut_reg == `DMMCH_CW_DISABLE ||
			(cmdOut_reg == `DMMCH_CW_SWITCHON && statWord[7:0] == `DMMCH_ST_SWON_LO)) begin
			modeOut_reg <= mode_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			refused_reg <= 1'b0;
		end else if (cmdPulse) begin
			refused_reg <= !cmdOk;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= `DMMCH_RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= arMapped ? `DMMCH_RESP_OKAY : `DMMCH_RESP_SLVERR;
			rdata_reg <= 32'h0;
			if (arMapped) begin
				unique case (s_axi_araddr[3:2])
					`DMMCH_IDX_MODE: rdata_reg <= {dispWord, mode_reg};
					`DMMCH_IDX_CMD: rdata_reg <= {16'h0000, cmdOut_reg};
					`DMMCH_IDX_STATUS: rdata_reg <= {dispWord, statWord};
					`DMMCH_IDX_STATE: rdata_reg <= {24'h0, modePending, refused_reg,
						targetReached, posActive, busy, state_reg};
				endcase
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	AST_SEQ_SHUTDOWN: assert property (
		state_reg == ST_DISV && statWord == `DMMCH_ST_DISABLED && !cmdPulse
		|=> cmdOut_reg == `DMMCH_CW_SHUTDOWN && state_reg == ST_SHUT)
		else $error("shutdown word not sent after disabled reply");

	AST_SEQ_SWITCHON: assert property (
		state_reg == ST_SHUT && statWord == `DMMCH_ST_READY && !cmdPulse
		|=> cmdOut_reg == `DMMCH_CW_SWITCHON)
		else $error("switch-on word not sent after ready reply");

	AST_SEQ_ORDER: assert property (
		$changed(cmdOut_reg) && cmdOut_reg == `DMMCH_CW_ENABLE && $past(state_reg) == ST_SWON
		|-> $past(cmdOut_reg) == `DMMCH_CW_SWITCHON && $past(statWord) == `DMMCH_ST_SWON)
		else $error("enable sent out of order");

	AST_START_WORD: assert property (
		cmdPulse && cmdOk && opIn == OP_START
		|=> cmdOut_reg == (`DMMCH_CW_START | {$past(blkIn), 11'h000}))
		else $error("start word wrong");

	AST_SEQ_WORD: assert property (
		cmdPulse && cmdOk && opIn == OP_START_SEQ && blkIn == 5'h00
		|=> cmdOut_reg == 16'h021f)
		else $error("sequence start word wrong");

	AST_RESUME_WORD: assert property (
		cmdPulse && cmdOk && (opIn == OP_RESUME || opIn == OP_RESUME_SEQ)
		|=> cmdOut_reg == ($past(opIn) == OP_RESUME ? 16'h004f : 16'h005f))
		else $error("resume word wrong");

	AST_GO_HELD: assert property (
		cmdOut_reg[`DMMCH_CW_GO_BIT] && !(cmdPulse && (opIn == OP_STOP || opIn == OP_DISABLE))
		|=> cmdOut_reg[`DMMCH_CW_GO_BIT])
		else $error("start bit dropped without stop");

	AST_MOTION_GATED: assert property (
		cmdPulse && state_reg != ST_READY && opIn != OP_POWERUP && opIn != OP_DISABLE &&
		opIn != OP_NONE |=> refused_reg && ($past(state_reg) != ST_IDLE || $stable(cmdOut_reg)))
		else $error("motion command taken outside operation enabled");

	AST_MODE_FROZEN: assert property (
		cmdOut_reg[3:0] == `DMMCH_CW_ENABLE_NIB && $past(cmdOut_reg[3:0]) == `DMMCH_CW_ENABLE_NIB
		|-> $stable(modeOut_reg))
		else $error("mode changed while operation enabled");

	AST_LIMIT_MODE: assert property (
		cmdOut_reg == `DMMCH_CW_CLRLIM |-> modeOut_reg == `DMMCH_MODE_LIMIT)
		else $error("clear-limit sent outside limit mode");

	AST_WRITE_ANSWER: assert property (
		wrEn |=> bvalid_reg [*1] ##0 (s_axi_bready || bvalid_reg))
		else $error("write not answered");

	AST_RESUME_GATED: assert property (
		cmdPulse && (opIn == OP_RESUME || opIn == OP_RESUME_SEQ) && cmdOut_reg[`DMMCH_CW_GO_BIT]
		|=> refused_reg && $stable(cmdOut_reg))
		else $error("resume taken while start bit high");

	AST_MODE_BEFORE_ENABLE: assert property (
		state_reg == ST_SWON && modePending && !cmdPulse |=> state_reg == ST_SWON)
		else $error("operation enabled before the new mode went out");

	COV_READY: cover property (state_reg == ST_ENOP ##1 state_reg == ST_READY);
	COV_START: cover property (cmdPulse && cmdOk && opIn == OP_START && blkIn == 5'h02);
	COV_CLEAR: cover property (cmdOut_reg == `DMMCH_CW_CLRLIM ##[1:20] targetReached);
	COV_HALT: cover property (cmdOut_reg[8] ##[1:20] !cmdOut_reg[8]);
	COV_REFUSED: cover property (cmdPulse && !cmdOk);
endmodule

/* bench/dmmch_drive_model.sv */
module dmmch_drive_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [15:0] cmdWord,
	input wire logic [15:0] modeWord,
	output logic [15:0] statusWord,
	output logic [15:0] modeDisplay
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] prevCmd;
	logic [3:0] cnt;
	logic go;
	logic prevGo;
	// only bits assigned in the active mode start motion
	assign go = (modeWord == 16'hfffe) ? cmdWord[4] : (cmdWord[9] | cmdWord[6]);
	always_ff @(posedge clk) begin
		modeDisplay <= modeWord;
		prevCmd <= cmdWord;
		prevGo <= go;
		if (reset) begin
			statusWord <= 16'h0050;
			cnt <= 4'h0;
		end else if (cmdWord[3:0] != 4'hf) begin
			cnt <= 4'h0;
			case (cmdWord[3:0])
				4'h6: statusWord <= 16'h0031;
				4'h7: statusWord <= 16'h0033;
				default: statusWord <= 16'h0050;
			endcase
		end else if (cmdWord[8] || !go) begin
			statusWord <= 16'h0637;
			cnt <= 4'h0;
		end else if (!prevGo || prevCmd[8]) begin
			statusWord <= (modeWord == 16'hfffe) ? 16'h02b7 : 16'h0337;
			cnt <= 4'hf;
		end else if (cnt == 4'h1) begin
			statusWord <= 16'h0637;
			cnt <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule

/* bench/dmmch_host_tb.sv */
module dmmch_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic reset = 1;
	logic [7:0] awaddr = 0;
	logic [7:0] araddr = 0;
	logic awvalid = 0;
	logic wvalid = 0;
	logic bready = 0;
	logic arvalid = 0;
	logic rready = 0;
	logic [31:0] wdata = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic [15:0] cmdOut, modeOut, statIn, dispIn;
	int fail_count = 0;
	int compares = 0;
	dmmch_host dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.outboundProcessWordOne(cmdOut), .outboundModeSelectWord(modeOut),
		.inboundProcessWordOne(statIn), .inboundModeDisplayWord(dispIn));
	dmmch_drive_model drive (.clk(clk), .reset(reset), .cmdWord(cmdOut), .modeWord(modeOut),
		.statusWord(statIn), .modeDisplay(dispIn));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic tmo();
		fail_count++;
		$display("mismatch %0t wait timed out", $time);
		give_verdict();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// each handshake is judged at the negedge before the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ta, tw, da, dw, tb;
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		for (i = 0; i < 50 && !(da && dw); i++) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			da |= ta;
			dw |= tw;
		end
		if (!(da && dw)) tmo();
		bready <= 1;
		for (i = 0; i < 50 && !tb; i++) begin
			@(negedge clk);
			tb = bvalid;
			rs = bresp;
			@(posedge clk);
		end
		bready <= 0;
		if (!tb) tmo();
	endtask
	task automatic rdd(input logic [7:0] a);
		bit t, tr;
		int i;
		araddr <= a;
		arvalid <= 1;
		for (i = 0; i < 50 && !t; i++) begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
		end
		if (!t) tmo();
		arvalid <= 0;
		rready <= 1;
		for (i = 0; i < 50 && !tr; i++) begin
			@(negedge clk);
			tr = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge clk);
		end
		rready <= 0;
		if (!tr) tmo();
	endtask
	task automatic op(input logic [3:0] o, input logic [4:0] b, input logic [15:0] exp);
		wr(8'h04, {23'h0, b, o});
		@(negedge clk);
		chk({16'h0, cmdOut}, {16'h0, exp}, "command word");
		@(posedge clk);
	endtask
	task automatic waitSt(input logic [7:0] m, input logic [7:0] v);
		int i;
		for (i = 0; i < 100; i++) begin
			rdd(8'h0c);
			if ((rd[7:0] & m) === v) break;
		end
		compares++;
		if (i == 100) tmo();
	endtask
	task automatic powerup(input logic [15:0] m);
		wr(8'h00, {16'h0, m});
		wr(8'h04, 32'h1);
		waitSt(8'h07, 8'h07);
		@(negedge clk);
		chk({modeOut, cmdOut}, {m, 16'h000f}, "ready words");
		@(posedge clk);
	endtask
	task automatic test_reset();
		rdd(8'h0c);
		chk(rd, 32'h0, "state after reset");
		rdd(8'h04);
		chk(rd, 32'h0, "command register after reset");
		chk({modeOut, cmdOut}, 32'h0, "words after reset");
		op(4'h2, 5'h0, 16'h0000);
		rdd(8'h0c);
		chk(rd, 32'h40, "start refused before power-up");
		$display("test reset done");
	endtask
	task automatic test_table();
		powerup(16'hffff);
		for (int b = 0; b < 3; b++) begin
			op(4'h2, b[4:0], {b[4:0], 11'h20f});
			waitSt(8'h10, 8'h10);
			waitSt(8'h30, 8'h20);
			op(4'h6, 5'h0, 16'h000f);
		end
		op(4'h3, 5'h0, 16'h021f);
		op(4'h2, 5'h3, 16'h021f);
		rdd(8'h0c);
		chk({31'h0, rd[6]}, 32'h1, "start refused while running");
		op(4'h4, 5'h0, 16'h021f);
		op(4'h6, 5'h0, 16'h000f);
		op(4'h4, 5'h0, 16'h004f);
		waitSt(8'h10, 8'h10);
		op(4'h6, 5'h0, 16'h000f);
		op(4'h5, 5'h0, 16'h005f);
		op(4'h6, 5'h0, 16'h000f);
		op(4'h7, 5'h0, 16'h000f);
		op(4'hb, 5'h0, 16'h000f);
		rdd(8'h0c);
		chk({31'h0, rd[6]}, 32'h1, "bad op refused");
		wr(8'h10, 32'h1);
		chk({30'h0, rs}, 32'h2, "unmapped write");
		rdd(8'h10);
		chk(rd | rs, 32'h2, "unmapped read");
		$display("test table done");
	endtask
	task automatic test_limit();
		wr(8'h00, 32'hfffe);
		rdd(8'h0c);
		chk({rd[7], 15'h0, modeOut}, 32'h8000ffff, "mode held while enabled");
		op(4'ha, 5'h0, 16'h0000);
		powerup(16'hfffe);
		op(4'h7, 5'h0, 16'h001f);
		waitSt(8'h20, 8'h00);
		waitSt(8'h20, 8'h20);
		op(4'h8, 5'h0, 16'h011f);
		op(4'h9, 5'h0, 16'h001f);
		waitSt(8'h20, 8'h00);
		waitSt(8'h20, 8'h20);
		rdd(8'h08);
		chk({16'h0, rd[31:16]}, 32'hfffe, "mode display");
		$display("test limit done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		test_reset();
		test_table();
		test_limit();
		give_verdict();
	end
endmodule
